// File: design/split_watchdog_defs.svh
/*
 * Constants for the split-port link watchdog: register offsets, reset
 * values, field positions and timing figures in milliseconds.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef SPLIT_WATCHDOG_DEFS_SVH
`define SPLIT_WATCHDOG_DEFS_SVH

// ****************************************
// Register offsets and reset values
// ****************************************
`define TIMEOUT_SEL_ADDR      16'h4171
`define OFF_DUR_ADDR          16'h4176
`define TIMEOUT_SEL_RESET     8'h05
`define OFF_DUR_RESET         8'h05

// ****************************************
// Field layout
// ****************************************
`define TIMEOUT_FIELD_MSB     2
`define TIMEOUT_FIELD_LSB     0

// ****************************************
// Timeout codes and link state codes
// ****************************************
`define TMO_CODE_OFF          3'h0
`define TMO_CODE_100MS        3'h1
`define TMO_CODE_250MS        3'h2
`define TMO_CODE_500MS        3'h3
`define TMO_CODE_750MS        3'h4
`define TMO_CODE_1S           3'h5
`define TMO_CODE_2S           3'h6
`define LINK_BAD_LO           4'h4
`define LINK_BAD_HI           4'h9

// ****************************************
// Times in milliseconds
// ****************************************
`define TMO_100_MS            12'd100
`define TMO_250_MS            12'd250
`define TMO_500_MS            12'd500
`define TMO_750_MS            12'd750
`define TMO_1000_MS           12'd1000
`define TMO_2000_MS           12'd2000
`define OFF_BASE_MS           12'd350
`define OFF_STEP_MS           12'd10

// ****************************************
// Clock
// ****************************************
`define CLK_HZ                40000000
`define MS_PER_S              1000

`endif

// File: design/split_watchdog_pkg.sv
/*
 * Types for the split-port link watchdog.
 * Assumes split_watchdog_defs.svh holds every number.
 */
`default_nettype none
package split_watchdog_pkg;

   // ****************************************
   // Per-port watchdog state
   // ****************************************
   typedef enum logic [0:0] {
      WD_MONITOR,
      WD_POWER_OFF
   } wd_state_t;

endpackage
`default_nettype wire

// File: design/split_port_link_watchdog.sv
/*
 * Link watchdog for the split downstream ports (ports 4 and 5). Each port
 * watches its link state; a link stuck in a bad state for the global
 * timeout gets its SuperSpeed power output pulled low for a set time.
 * Assumes hub clock/reset, same-clock split enables and link states, and a
 * simple register access port at the printed offsets.
 */
`timescale 1ns/1ps
`default_nettype none
`include "split_watchdog_defs.svh"

module split_port_link_watchdog
   import split_watchdog_pkg::*;
#(
   parameter int NUM_PORTS     = 2,
   parameter int CYCLES_PER_MS = `CLK_HZ / `MS_PER_S
) (
   input  wire logic                   mclk_in,
   input  wire logic                   nrst_in,
   input  wire logic [15:0]            reg_addr_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   input  wire logic [7:0]             reg_wdata_in,
   output logic      [7:0]             reg_rdata_out,
   input  wire logic [NUM_PORTS-1:0]   split_enable_in,
   input  wire logic [4*NUM_PORTS-1:0] link_state_status_in,
   output logic      [NUM_PORTS-1:0]   superspeed_port_power_out
);

   // ****************************************
   // Helper functions
   // ****************************************

   // Timeout code to milliseconds; zero for off or reserved
   function automatic logic [11:0] timeout_ms(input logic [2:0] code);
      logic [11:0] ms;
      case (code)
         `TMO_CODE_100MS: ms = `TMO_100_MS;
         `TMO_CODE_250MS: ms = `TMO_250_MS;
         `TMO_CODE_500MS: ms = `TMO_500_MS;
         `TMO_CODE_750MS: ms = `TMO_750_MS;
         `TMO_CODE_1S:    ms = `TMO_1000_MS;
         `TMO_CODE_2S:    ms = `TMO_2000_MS;
         default:         ms = 12'h000;
      endcase
      return ms;
   endfunction

   // Milliseconds to clock cycles
   function automatic logic [31:0] ms_to_cycles(input logic [11:0] ms);
      logic [63:0] prod;
      prod = 64'(ms) * 64'(CYCLES_PER_MS);
      return prod[31:0];
   endfunction

   // Off time in ms: base plus one step per unit
   function automatic logic [11:0] off_time_ms(input logic [7:0] dur);
      logic [11:0] ms;
      ms = 12'(`OFF_BASE_MS + `OFF_STEP_MS * {4'h0, dur});
      return ms;
   endfunction

   // True when one more tick reaches the limit
   function automatic logic last_tick(input logic [31:0] count,
                                      input logic [31:0] limit);
      logic [32:0] bumped;
      bumped = {1'b0, count} + 33'h0_0000_0001;
      return (bumped >= {1'b0, limit});
   endfunction

   // Link codes that count as stuck
   function automatic logic in_bad_range(input logic [3:0] code);
      return (code >= `LINK_BAD_LO) && (code <= `LINK_BAD_HI);
   endfunction

   // Exact address match at a register offset
   function automatic logic is_reg(input logic [15:0] addr, input logic [15:0] target);
      return (addr == target);
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   // Software-visible settings
   logic [2:0]  timeout_sel_q;
   logic [7:0]  off_dur_q;

   // Software writes at the printed offsets
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         timeout_sel_q <= 3'(`TIMEOUT_SEL_RESET);
         off_dur_q     <= `OFF_DUR_RESET;
      end else if (reg_wr_in) begin
         if (is_reg(reg_addr_in, `TIMEOUT_SEL_ADDR)) begin
            timeout_sel_q <= reg_wdata_in[`TIMEOUT_FIELD_MSB:`TIMEOUT_FIELD_LSB];
         end
         if (is_reg(reg_addr_in, `OFF_DUR_ADDR)) begin
            off_dur_q <= reg_wdata_in;
         end
      end
   end

   // Registered read data; unmapped offsets read zero
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `TIMEOUT_SEL_ADDR: reg_rdata_out <= {5'h00, timeout_sel_q};
            `OFF_DUR_ADDR:     reg_rdata_out <= off_dur_q;
            default:           reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // Shared limits
   // ****************************************
   logic [11:0] tmo_ms;
   logic [11:0] off_ms;
   logic [31:0] tmo_cycles;
   logic [31:0] off_cycles;
   logic        wd_enabled;

   // One timeout setting serves every port
   assign tmo_ms     = timeout_ms(timeout_sel_q);
   assign wd_enabled = (tmo_ms != 12'h000);
   assign tmo_cycles = ms_to_cycles(tmo_ms);
   // Off time 350 ms plus 10 ms per step
   assign off_ms     = off_time_ms(off_dur_q);
   // Settings read live; a change mid-toggle moves its end
   assign off_cycles = ms_to_cycles(off_ms);

   // ****************************************
   // Per-port watchdogs
   // ****************************************
   // Index 0 is port 4, index 1 is port 5
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      // Per-port state and decode
      wd_state_t   state_q;
      logic [31:0] count_q;

      logic [3:0]  lstate;
      logic        link_bad;
      logic        watching;
      logic        fire;
      logic        off_busy;

      assign lstate   = link_state_status_in[4*p +: 4];
      // Bad while the state sits in the stuck range
      assign link_bad = in_bad_range(lstate);
      // Timing only while split, enabled and stuck
      assign watching = split_enable_in[p] && wd_enabled && link_bad;
      // Last bad cycle of the timeout window
      assign fire     = (state_q == WD_MONITOR) && watching
                        && last_tick(count_q, tmo_cycles);
      // Off window still open after this edge
      assign off_busy = (state_q == WD_POWER_OFF)
                        && !last_tick(count_q, off_cycles);

      // Monitor and toggle sequence for one port
      always_ff @(posedge mclk_in) begin
         if (!nrst_in) begin
            state_q <= WD_MONITOR;
            count_q <= 32'h0000_0000;
         end else begin
            case (state_q)
               WD_MONITOR: begin
                  // Any good edge restarts the window
                  if (!watching) begin
                     count_q <= 32'h0000_0000;
                  end else if (fire) begin
                     count_q <= 32'h0000_0000;
                     state_q <= WD_POWER_OFF;
                  end else begin
                     count_q <= count_q + 32'h0000_0001;
                  end
               end
               WD_POWER_OFF: begin
                  // Toggle always completes once started
                  if (!off_busy) begin
                     count_q <= 32'h0000_0000;
                     state_q <= WD_MONITOR;
                  end else begin
                     count_q <= count_q + 32'h0000_0001;
                  end
               end
               default: begin
                  // Unreachable; recover to monitoring
                  state_q <= WD_MONITOR;
                  count_q <= 32'h0000_0000;
               end
            endcase
         end
      end

      // Power output low only during a watchdog toggle
      always_ff @(posedge mclk_in) begin
         if (!nrst_in) begin
            superspeed_port_power_out[p] <= 1'b1;
         end else begin
            superspeed_port_power_out[p] <= !(fire || off_busy);
         end
      end
   end

endmodule
`default_nettype wire

// File: bench/split_device_model.sv
/* Embedded device model behind one split power output.
   Assumes the hub clock; stuck_in makes its link hang. */
`timescale 1ns/1ps
`default_nettype none
module split_device_model (
   input  wire logic       mclk_in,
   input  wire logic       power_in,
   input  wire logic       stuck_in,
   output logic      [3:0] state_out
);
   // Unpowered: detect; hung: bounce between bad codes; else active
   always_ff @(posedge mclk_in) begin
      if (!power_in) state_out <= 4'h5;
      else if (stuck_in) state_out <= (state_out == 4'h7) ? 4'h8 : 4'h7;
      else state_out <= 4'h0;
   end
endmodule
`default_nettype wire

// File: bench/split_port_link_watchdog_chk.sv
/* Port checker for the split link watchdog.
   Assumes register writes take effect next cycle, live settings. */
`timescale 1ns/1ps
`default_nettype none
module split_port_link_watchdog_chk #(
   parameter int NUM_PORTS     = 2,
   parameter int CYCLES_PER_MS = 1
) (
   input wire logic                   mclk_in,
   input wire logic                   nrst_in,
   input wire logic [15:0]            reg_addr_in,
   input wire logic                   reg_wr_in,
   input wire logic                   reg_rd_in,
   input wire logic [7:0]             reg_wdata_in,
   input wire logic [7:0]             reg_rdata_out,
   input wire logic [NUM_PORTS-1:0]   split_enable_in,
   input wire logic [4*NUM_PORTS-1:0] link_state_status_in,
   input wire logic [NUM_PORTS-1:0]   superspeed_port_power_out
);
   localparam int MS[8] = '{0, 100, 250, 500, 750, 1000, 2000, 0};
   logic [2:0] tmo_q;
   logic [7:0] off_q;
   int         bc_q;
   int         lo_q;
   int         lim;
   logic       bad;
   logic [1:0] pw;
   assign pw = superspeed_port_power_out[1:0];
   assign lim = MS[tmo_q] * CYCLES_PER_MS;
   assign bad = split_enable_in[0] && pw[0] && lim != 0
                && link_state_status_in[3:0] inside {[4'h4:4'h9]};
   // Shadow settings, bad-run and low-run counters of port 4
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         tmo_q <= 3'h5;
         off_q <= 8'h05;
         bc_q <= 0;
         lo_q <= 0;
      end else begin
         if (reg_wr_in && reg_addr_in == 16'h4171) tmo_q <= reg_wdata_in[2:0];
         if (reg_wr_in && reg_addr_in == 16'h4176) off_q <= reg_wdata_in;
         bc_q <= bad ? bc_q + 1 : 0;
         lo_q <= pw[0] ? 0 : lo_q + 1;
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   property p_fire; bad && bc_q == lim - 1 |=> !pw[0]; endproperty
   a_fire: assert property (p_fire) else $error("power not dropped at timeout");
   property p_early; bad && bc_q < lim - 1 |=> pw[0]; endproperty
   a_early: assert property (p_early) else $error("power dropped early");
   property p_off; lim == 0 && pw[0] |=> pw[0]; endproperty
   a_off: assert property (p_off) else $error("toggle while disabled");
   property p_cause;
      $fell(pw[0]) |-> $past(split_enable_in[0])
                       && $past(link_state_status_in[3:0]) inside {[4'h4:4'h9]};
   endproperty
   a_cause: assert property (p_cause) else $error("toggle without bad link");
   property p_len; $rose(pw[0]) && $past(nrst_in) |-> lo_q == (350 + 10 * off_q) * CYCLES_PER_MS;
   endproperty
   a_len: assert property (p_len) else $error("wrong off time");
   property p_hold; $rose(pw[0]) |=> pw[0][*8]; endproperty
   a_hold: assert property (p_hold) else $error("no restart after toggle");
   property p_port5; !split_enable_in[1] && pw[1] |=> pw[1]; endproperty
   a_port5: assert property (p_port5) else $error("toggle on unsplit port");
   property p_rsvd; reg_rd_in && reg_addr_in == 16'h4171 |=> reg_rdata_out[7:3] == 5'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
endmodule
bind split_port_link_watchdog split_port_link_watchdog_chk #(
   .NUM_PORTS(NUM_PORTS), .CYCLES_PER_MS(CYCLES_PER_MS)) chk_u (
   .mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out), .split_enable_in(split_enable_in),
   .link_state_status_in(link_state_status_in),
   .superspeed_port_power_out(superspeed_port_power_out));
`default_nettype wire

// File: bench/split_port_link_watchdog_tb.sv
/* Self-checking bench for the split link watchdog, one ms = one cycle.
   Assumes the device models drive the link states. */
`timescale 1ns/1ps
`default_nettype none
module split_port_link_watchdog_tb;
   logic        mclk_in = 1'b0;
   logic        nrst_in = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   logic [1:0]  split_en = 2'b00;
   logic [1:0]  stuck = 2'b00;
   logic [1:0]  pw;
   logic [1:0]  lo_seen = 2'b00;
   logic [7:0]  ls;
   int          error_cnt = 0;
   int          checks_done = 0;
   localparam int MS_TAB[6] = '{100, 250, 500, 750, 1000, 2000};
   always #12.5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) lo_seen = lo_seen | ~pw;
   split_port_link_watchdog #(.NUM_PORTS(2), .CYCLES_PER_MS(1)) dut_u (
      .mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(addr), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .split_enable_in(split_en), .link_state_status_in(ls),
      .superspeed_port_power_out(pw));
   split_device_model dev4_u (.mclk_in(mclk_in), .power_in(pw[0]), .stuck_in(stuck[0]),
      .state_out(ls[3:0]));
   split_device_model dev5_u (.mclk_in(mclk_in), .power_in(pw[1]), .stuck_in(stuck[1]),
      .state_out(ls[7:4]));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge mclk_in);
      #1 wr = 1'b0;
      @(posedge mclk_in);
      #1;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1'b1;
      @(posedge mclk_in);
      #1 rd = 1'b0;
      chk("reg_rdata_out", {24'h00_0000, exp}, {24'h00_0000, rdata});
      @(posedge mclk_in);
      #1;
   endtask
   // Cycles until power of port index p reaches level v
   task automatic wait_lvl(input int p, input logic v, output int n);
      n = 0;
      do begin
         @(posedge mclk_in);
         #1 n++;
      end while (pw[p] !== v && n < 5000);
   endtask
   // Port 5 toggles alone while port 4 is not split
   task automatic t_port5();
      int n;
      split_en = 2'b10;
      stuck = 2'b11;
      wr_reg(16'h4171, 8'h01);
      wr_reg(16'h4176, 8'h00);
      lo_seen = 2'b00;
      wait_lvl(1, 1'b0, n);
      wait_lvl(1, 1'b1, n);
      chk("port 5 low cycles", 350, n);
      wait_lvl(1, 1'b0, n);
      chk("port 5 high cycles", 100, n);
      chk("port 4 low", 32'h0, {31'h0, lo_seen[0]});
      wait_lvl(1, 1'b1, n);
      $display("t_port5 done");
   endtask
   task automatic t_regs();
      rd_chk(16'h4171, 8'h05);
      rd_chk(16'h4176, 8'h05);
      wr_reg(16'h4171, 8'hFF);
      rd_chk(16'h4171, 8'h07);
      rd_chk(16'h4000, 8'h00);
      $display("t_regs done");
   endtask
   // Hung links must not toggle for this setting
   task automatic t_quiet(input logic [7:0] code, input logic [1:0] en);
      split_en = en;
      wr_reg(16'h4171, code);
      stuck = 2'b11;
      lo_seen = 2'b00;
      repeat (300) @(posedge mclk_in);
      #1 chk("power low seen", 32'h0, {30'h0, lo_seen});
      $display("t_quiet %0h done", code);
   endtask
   // One full toggle period on port 4, port 5 healthy
   task automatic t_toggle(input logic [2:0] code, input logic [7:0] off, input int t_ms);
      int n;
      split_en = 2'b11;
      stuck = 2'b01;
      wr_reg(16'h4171, {5'h00, code});
      wr_reg(16'h4176, off);
      lo_seen = 2'b00;
      wait_lvl(0, 1'b1, n);
      wait_lvl(0, 1'b0, n);
      wait_lvl(0, 1'b1, n);
      chk("low cycles", 350 + 10 * off, n);
      wait_lvl(0, 1'b0, n);
      chk("high cycles", t_ms, n);
      chk("port 5 low", 32'h0, {31'h0, lo_seen[1]});
      $display("t_toggle %0d done", code);
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge mclk_in);
      #1 nrst_in = 1'b1;
      t_regs();
      t_quiet(8'h07, 2'b11);
      t_quiet(8'h00, 2'b11);
      t_quiet(8'h01, 2'b00);
      t_port5();
      for (int i = 0; i < 6; i++) t_toggle(3'(i + 1), 8'(i * 51), MS_TAB[i]);
      test_done();
   end
   // Watchdog against a hang
   initial begin
      repeat (60000) @(posedge mclk_in);
      error_cnt++;
      test_done();
   end
endmodule
`default_nettype wire
